//--- fault_trip_latch_manager.sv
// Fault trip latching, reset handling, history and AXI4-Lite register access
// ==========================================================
// Overview of operation
// - Any trip inhibits the power stage at once
// - Trip latches hold until explicit reset
// - Reset ignored while trip source present
// - Enable refused while any latch set
// - Independent latches, several set together
// - Trip flashes indicator, sets fault flag
// - Healthy_status_indicator output follows flag, selectable polarity
// - Acknowledge clears message, not the latch
// - Power cycle, key or remote clear resets
// - Remote mode: run re-assertion resets trips
// - Reset returns indicator steady, flag false
// - Auto recovery resets after preset delay
// - Active, disabled, warning sets as words
// - Blocked key raises separate alert
// - Disabled-trips setting masks trip sources
`timescale 1ns/1ns
module fault_trip_latch_manager
    import trip_pkg::*;
#(
    parameter int unsigned AUTO_CYCLES  = AUTO_DELAY_CYC,
    parameter int unsigned FLASH_CYCLES = FLASH_HALF_CYC
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [NUM_TRIPS-1:0] trip_source,
    input  wire logic [NUM_TRIPS-1:0] warn_source,
    input  wire logic                 drive_enable_req,
    input  wire logic                 halt_clear_key,
    input  wire logic                 ack_key,
    input  wire logic                 key_attempt_blocked,
    input  wire logic                 remote_clear_input,
    input  wire logic                 run_command_input,
    output logic                      power_stage_enable,
    output logic                      tripped_flag,
    output logic                      healthy_status_indicator,
    output logic                      healthy_status_indicator_output,
    output logic                      trip_message,
    output logic                      key_blocked_alert,
    output logic                      auto_recovery_enable,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready
);

    trip_state_s_t st_ff;
    trip_state_s_t nxt_st;

    logic [NUM_TRIPS-1:0] armed;
    logic [NUM_TRIPS-1:0] new_trips;
    logic                 any_latched;
    logic                 reset_req;
    logic                 run_rise;
    logic                 wr_fire;
    logic                 sw_reset;
    logic                 sw_ack;
    logic                 sw_alert;
    code_t                new_code;
    logic                 new_found;
    logic [31:0]          rd_word;
    logic                 rd_ok;
    logic [31:0]          wr_word;

    // ==========================================================
    // Trip detection
    assign armed       = trip_source & ~st_ff.disabled;
    assign new_trips   = armed & ~st_ff.latched;
    assign any_latched = |st_ff.latched;
    assign run_rise    = run_command_input & ~st_ff.run_prev;

    // Lowest numbered newly arriving trip gives the recorded code
    always_comb begin
        new_code  = '0;
        new_found = 1'b0;
        for (int i = NUM_TRIPS - 1; i >= 0; i--) begin
            if (new_trips[i]) begin
                new_code  = code_t'(i + 1);
                new_found = 1'b1;
            end
        end
    end

    // ==========================================================
    // AXI4-Lite handshake helpers
    assign s_axi_awready = !st_ff.aw_seen && !st_ff.bvalid;
    assign s_axi_wready  = !st_ff.w_seen && !st_ff.bvalid;
    assign s_axi_arready = !st_ff.rvalid;
    assign s_axi_bvalid  = st_ff.bvalid;
    assign s_axi_bresp   = st_ff.bresp;
    assign s_axi_rvalid  = st_ff.rvalid;
    assign s_axi_rdata   = st_ff.rdata;
    assign s_axi_rresp   = st_ff.rresp;

    // Write completes once both halves are held
    assign wr_fire  = st_ff.aw_seen && st_ff.w_seen && !st_ff.bvalid;
    assign sw_reset = wr_fire && st_ff.aw_addr == ADDR_CMD
                      && st_ff.wdata[CMD_RESET_BIT];
    assign sw_ack   = wr_fire && st_ff.aw_addr == ADDR_CMD
                      && st_ff.wdata[CMD_ACK_BIT];
    assign sw_alert = wr_fire && st_ff.aw_addr == ADDR_CMD
                      && st_ff.wdata[CMD_ALERT_BIT];

    assign reset_req = halt_clear_key || remote_clear_input || sw_reset
                     || (st_ff.ctrl[CTRL_REMOTE_BIT] && run_rise);

    // Read decode; history entries sit one word apart
    always_comb begin
        rd_word = '0;
        rd_ok   = 1'b1;
        case (s_axi_araddr)
            ADDR_CTRL:     rd_word = {29'h0, st_ff.ctrl};
            ADDR_DISABLED: rd_word = {16'h0, st_ff.disabled};
            ADDR_ACTIVE:   rd_word = {16'h0, st_ff.latched};
            ADDR_WARN:     rd_word = {16'h0, st_ff.warn};
            ADDR_FIRST:    rd_word = {26'h0, st_ff.first_valid,
                                      st_ff.first};
            ADDR_STATUS:   rd_word = {27'h0, st_ff.key_alert,
                                      st_ff.msg_shown, st_ff.state,
                                      any_latched};
            ADDR_CMD:      rd_word = 32'h0;
            default: begin
                if (s_axi_araddr >= ADDR_HIST0 && s_axi_araddr[1:0] == 2'h0
                    && s_axi_araddr < ADDR_HIST0 + 8'(4 * HIST_DEPTH)) begin
                    rd_word = {27'h0,
                        st_ff.hist[4'((s_axi_araddr - ADDR_HIST0) >> 2)]};
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
    end

    // Byte-lane merge for the writable words
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    assign wr_word = st_ff.wdata;

    // ==========================================================
    // Next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.run_prev = run_command_input;
        nxt_st.warn     = warn_source;

        // Bus channels
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_st.aw_seen = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_st.w_seen = 1'b1;
            nxt_st.wdata  = merge(32'h0, s_axi_wdata, s_axi_wstrb);
        end
        if (wr_fire) begin
            nxt_st.aw_seen = 1'b0;
            nxt_st.w_seen  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            nxt_st.bresp   = AXI_OKAY;
            case (st_ff.aw_addr)
                ADDR_CTRL:     nxt_st.ctrl = wr_word[2:0];
                ADDR_DISABLED: nxt_st.disabled = wr_word[15:0];
                ADDR_CMD:      nxt_st.ctrl = st_ff.ctrl;
                default:       nxt_st.bresp = AXI_SLVERR;
            endcase
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata  = rd_word;
            nxt_st.rresp  = rd_ok ? AXI_OKAY : AXI_SLVERR;
        end else if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end

        // Alert for blocked keys, kept apart from trips
        if (ack_key || sw_ack) begin
            nxt_st.msg_shown = 1'b0;
            nxt_st.key_alert = 1'b0;
        end
        if (key_attempt_blocked || sw_alert) begin
            nxt_st.key_alert = 1'b1;
        end

        // Reset clears only latches whose source has gone
        if (reset_req) begin
            nxt_st.latched = st_ff.latched & armed;
        end
        if (st_ff.state == ST_WAIT && st_ff.auto_cnt == 32'h0) begin
            nxt_st.latched = st_ff.latched & armed;
        end
        // A new trip wins over any clear in the same cycle
        nxt_st.latched = nxt_st.latched | armed;
        if (new_found) begin
            nxt_st.msg_shown = 1'b1;
            nxt_st.hist = {st_ff.hist[HIST_DEPTH-2:0], new_code};
            if (!any_latched && !st_ff.first_valid) begin
                nxt_st.first       = new_code;
                nxt_st.first_valid = 1'b1;
            end
        end
        if (nxt_st.latched == '0 && any_latched && !new_found) begin
            nxt_st.first_valid = 1'b0;
        end

        // Indicator flash timing while tripped
        if (any_latched) begin
            if (st_ff.flash_cnt >= FLASH_CYCLES - 1) begin
                nxt_st.flash_cnt = 32'h0;
                nxt_st.flash     = ~st_ff.flash;
            end else begin
                nxt_st.flash_cnt = st_ff.flash_cnt + 32'h1;
            end
        end else begin
            nxt_st.flash_cnt = 32'h0;
            nxt_st.flash     = 1'b0;
        end

        // Supervisor state
        case (st_ff.state)
            ST_HEALTHY: begin
                if (|armed) begin
                    nxt_st.state = ST_TRIPPED;
                end
            end
            ST_TRIPPED: begin
                if (nxt_st.latched == '0) begin
                    nxt_st.state = ST_HEALTHY;
                end else if (st_ff.ctrl[CTRL_AUTO_BIT]) begin
                    nxt_st.state    = ST_WAIT;
                    nxt_st.auto_cnt = AUTO_CYCLES - 1;
                end
            end
            ST_WAIT: begin
                if (nxt_st.latched == '0) begin
                    nxt_st.state = ST_HEALTHY;
                end else if (!st_ff.ctrl[CTRL_AUTO_BIT]
                             || st_ff.auto_cnt == 32'h0) begin
                    nxt_st.state = ST_TRIPPED;
                end else begin
                    nxt_st.auto_cnt = st_ff.auto_cnt - 32'h1;
                end
            end
            default: nxt_st.state = ST_HEALTHY;
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff          <= '0;
            st_ff.ctrl     <= CTRL_RESET;
            st_ff.disabled <= DISABLED_RESET;
            st_ff.state    <= ST_HEALTHY;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // Outputs; power-on reset alone also clears all latches
    // Combinational gating so a trip cuts the stage in its own cycle
    assign power_stage_enable = drive_enable_req && !any_latched
                                && !(|armed);
    assign tripped_flag             = any_latched;
    assign healthy_status_indicator = !any_latched || st_ff.flash;
    assign healthy_status_indicator_output = !any_latched ^ st_ff.ctrl[CTRL_INVERT_BIT];
    assign trip_message         = st_ff.msg_shown;
    assign key_blocked_alert    = st_ff.key_alert;
    assign auto_recovery_enable = st_ff.ctrl[CTRL_AUTO_BIT];

endmodule

//--- trip_pkg.sv
// Package: constants, register map and state carrier for the trip latch manager
package trip_pkg;

    // ==========================================================
    // Sizes
    localparam int unsigned NUM_TRIPS   = 16;
    localparam int unsigned HIST_DEPTH  = 10;
    localparam int unsigned CODE_W      = 5;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_DISABLED = 8'h04;
    localparam logic [7:0] ADDR_ACTIVE   = 8'h08;
    localparam logic [7:0] ADDR_WARN     = 8'h0c;
    localparam logic [7:0] ADDR_FIRST    = 8'h10;
    localparam logic [7:0] ADDR_STATUS   = 8'h14;
    localparam logic [7:0] ADDR_CMD      = 8'h18;
    localparam logic [7:0] ADDR_HIST0    = 8'h20;

    // ==========================================================
    // Control register fields
    localparam int unsigned CTRL_AUTO_BIT   = 0;
    localparam int unsigned CTRL_INVERT_BIT = 1;
    localparam int unsigned CTRL_REMOTE_BIT = 2;
    // Command register fields (write one to act)
    localparam int unsigned CMD_RESET_BIT = 0;
    localparam int unsigned CMD_ACK_BIT   = 1;
    localparam int unsigned CMD_ALERT_BIT = 2;

    // ==========================================================
    // Reset values
    localparam logic [2:0]  CTRL_RESET     = 3'h0;
    localparam logic [15:0] DISABLED_RESET = 16'h0000;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_MHZ        = 250;
    localparam int unsigned AUTO_DELAY_MS  = 5000;
    localparam int unsigned AUTO_DELAY_CYC = AUTO_DELAY_MS * CLK_MHZ * 1000;
    localparam int unsigned FLASH_HALF_MS  = 250;
    localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * CLK_MHZ * 1000;

    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef logic [CODE_W-1:0] code_t;

    typedef enum logic [1:0] {
        ST_HEALTHY = 2'h0,
        ST_TRIPPED = 2'h1,
        ST_WAIT    = 2'h3
    } trip_state_t;

    typedef struct packed {
        logic [2:0]            ctrl;
        logic [NUM_TRIPS-1:0]  disabled;
        logic [NUM_TRIPS-1:0]  latched;
        logic [NUM_TRIPS-1:0]  warn;
        code_t                 first;
        logic                  first_valid;
        code_t [HIST_DEPTH-1:0] hist;
        logic                  msg_shown;
        logic                  key_alert;
        trip_state_t           state;
        logic [31:0]           auto_cnt;
        logic [31:0]           flash_cnt;
        logic                  flash;
        logic                  run_prev;
        logic                  aw_seen;
        logic                  w_seen;
        logic [7:0]            aw_addr;
        logic [31:0]           wdata;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
    } trip_state_s_t;

endpackage

//--- fault_trip_latch_manager_assertions.sv
// Checker of trip latching, indication and reset requests
`timescale 1ns/1ns
module trip_checker
    import trip_pkg::*;
#(
    parameter int unsigned AUTO_CYCLES  = 20,
    parameter int unsigned FLASH_CYCLES = 4
) (
    input wire logic                 aclk,
    input wire logic                 aresetn,
    input wire logic [NUM_TRIPS-1:0] trip_source,
    input wire logic                 drive_enable_req,
    input wire logic                 halt_clear_key,
    input wire logic                 ack_key,
    input wire logic                 key_attempt_blocked,
    input wire logic                 remote_clear_input,
    input wire logic                 run_command_input,
    input wire logic                 power_stage_enable,
    input wire logic                 tripped_flag,
    input wire logic                 healthy_status_indicator,
    input wire logic                 healthy_status_indicator_output,
    input wire logic                 trip_message,
    input wire logic                 key_blocked_alert,
    input wire logic                 auto_recovery_enable,
    input wire logic                 s_axi_awvalid,
    input wire logic                 s_axi_awready,
    input wire logic                 s_axi_bvalid
);
    // ==========================================================
    // Helper logic
    localparam int AW = AUTO_CYCLES + 4;
    logic        req_any;
    logic        ind_q_ff;
    int unsigned still_ff;
    // A register write in flight may carry a reset command or a new polarity
    assign req_any = halt_clear_key || remote_clear_input || run_command_input
                     || auto_recovery_enable || s_axi_awvalid || !s_axi_awready;
    always_ff @(posedge aclk) begin
        ind_q_ff <= healthy_status_indicator;
        if (!aresetn || !tripped_flag || ind_q_ff != healthy_status_indicator)
            still_ff <= 0;
        else
            still_ff <= still_ff + 1;
    end

    // ==========================================================
    // Properties
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_stage_inhibit: assert property (power_stage_enable |->
        drive_enable_req && !tripped_flag)
        else $error("power stage enabled while tripped");
    a_trip_sets: assert property ($rose(tripped_flag) |->
        $past(trip_source) != '0)
        else $error("fault flag rose without a trip source");
    a_flag_holds: assert property (tripped_flag && !req_any |=>
        tripped_flag)
        else $error("fault flag dropped without reset request");
    a_flag_fell: assert property ($fell(tripped_flag) && $past(aresetn)
        |-> $past(req_any))
        else $error("fault flag fell without a request");
    a_msg_ack: assert property (ack_key && trip_source == '0 |=>
        !trip_message)
        else $error("trip message not cleared by acknowledge");
    a_alert_set: assert property (key_attempt_blocked && !ack_key |=>
        key_blocked_alert)
        else $error("blocked key alert not raised");
    a_flash_period: assert property (tripped_flag |->
        still_ff <= FLASH_CYCLES + 1)
        else $error("indicator not flashing while tripped");
    a_steady_lamp: assert property (!tripped_flag [*2] |->
        healthy_status_indicator)
        else $error("indicator not steady while healthy");
    a_healthy_status_indicator_follows: assert property (s_axi_awready && !s_axi_bvalid
        && $past(aresetn) |->
        $changed(healthy_status_indicator_output) == $changed(tripped_flag))
        else $error("healthy_status_indicator output does not follow fault flag");
    a_auto_bound: assert property (auto_recovery_enable && tripped_flag
        && trip_source == '0 |-> ##[1:AW] !tripped_flag)
        else $error("automatic recovery did not clear the trip");
endmodule

bind fault_trip_latch_manager trip_checker #(
    .AUTO_CYCLES(AUTO_CYCLES),
    .FLASH_CYCLES(FLASH_CYCLES)
) i_chk (
    .aclk, .aresetn, .trip_source, .drive_enable_req, .halt_clear_key,
    .ack_key, .key_attempt_blocked, .remote_clear_input,
    .run_command_input, .power_stage_enable, .tripped_flag,
    .healthy_status_indicator, .healthy_status_indicator_output, .trip_message,
    .key_blocked_alert, .auto_recovery_enable, .s_axi_awvalid,
    .s_axi_awready, .s_axi_bvalid
);

//--- trip_operator_model.sv
// Keypad and remote terminal model that issues trip reset requests
`timescale 1ns/1ns
module trip_operator_model (
    input  wire logic       aclk,
    input  wire logic       go,
    input  wire logic [1:0] how,
    output logic            halt_clear_key,
    output logic            remote_clear_input,
    output logic            run_command_input
);
    int unsigned cnt_ff;
    logic [1:0]  sel_ff;
    initial begin
        cnt_ff = 0;
        sel_ff = 2'h0;
        halt_clear_key = 1'b0;
        remote_clear_input = 1'b0;
        run_command_input = 1'b0;
    end
    always @(posedge aclk) begin
        if (go) begin
            sel_ff <= how;
            cnt_ff <= 3;
        end else if (cnt_ff != 0) begin
            cnt_ff <= cnt_ff - 1;
        end
    end
    // Run idles low, so one high cycle is a deassert then reassert
    always @(posedge aclk) begin
        halt_clear_key     <= (cnt_ff == 2) && (sel_ff == 2'h0);
        remote_clear_input <= (cnt_ff != 0) && (sel_ff == 2'h1);
        run_command_input  <= (cnt_ff == 2) && (sel_ff == 2'h2);
    end
endmodule

//--- fault_trip_latch_manager_tb.sv
// Self-checking bench for the fault trip latch manager
`timescale 1ns/1ns
module fault_trip_latch_manager_tb
    import trip_pkg::*;
;
    localparam int unsigned AUTO  = 20;
    localparam int unsigned FLASH = 4;
    logic                 aclk, aresetn, drive_enable_req, ack_key, go;
    logic                 key_attempt_blocked, f;
    logic [1:0]           how;
    logic [NUM_TRIPS-1:0] trip_source, warn_source;
    logic                 power_stage_enable, tripped_flag, healthy_status_indicator_output;
    logic                 healthy_status_indicator, trip_message;
    logic                 key_blocked_alert, auto_recovery_enable;
    wire                  halt_clear_key, remote_clear_input;
    wire                  run_command_input;
    logic [7:0]           s_axi_awaddr, s_axi_araddr;
    logic [31:0]          s_axi_wdata, s_axi_rdata;
    logic [3:0]           s_axi_wstrb;
    logic [1:0]           s_axi_bresp, s_axi_rresp;
    logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic                 s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic                 s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic                 s_axi_rready;
    logic [33:0]          expq[$];
    int                   failures, n_tests;

    fault_trip_latch_manager #(.AUTO_CYCLES(AUTO), .FLASH_CYCLES(FLASH))
        i_dut (.*);
    trip_operator_model i_op (.*);

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // ==========================================================
    // Shared tasks
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic hang();
        failures++;
        stop_test();
    endtask
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        int n;
        @(posedge aclk);
        expq.push_back({r, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 40) hang();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        int n;
        @(posedge aclk);
        expq.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 40) hang();
    endtask
    // Source is held for one edge only, so the latch must keep it
    task automatic trip(input int b);
        @(posedge aclk);
        trip_source[b] <= 1'b1;
        #1 chk(power_stage_enable, 0);
        @(posedge aclk);
        trip_source[b] <= 1'b0;
        #1 chk(tripped_flag, 1);
    endtask
    task automatic clr(input int m);
        if (m < 3) begin
            @(posedge aclk);
            how <= m[1:0];
            go <= 1'b1;
            @(posedge aclk);
            go <= 1'b0;
            cyc(5);
        end else begin
            wr(ADDR_CMD, 32'h1, AXI_OKAY);
            cyc(2);
        end
    endtask

    // ==========================================================
    // Response monitor
    always @(posedge aclk) begin
        if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))
        begin
            if (expq.size() == 0)
                hang();
            else
                chk(s_axi_rvalid ? {s_axi_rresp, s_axi_rdata}
                    : {s_axi_bresp, 32'h0}, expq.pop_front());
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        int w;
        int m;
        {aresetn, drive_enable_req, ack_key, key_attempt_blocked} = '0;
        {go, how, trip_source, warn_source} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        failures = 0;
        n_tests = 0;
        w = $urandom(32'h6c7a);
        w = $urandom();
        cyc(2);
        aresetn <= 1'b1;
        cyc(1);
        #1 chk({tripped_flag, healthy_status_indicator, healthy_status_indicator_output}, 3);
        rd(ADDR_CTRL, 32'h0, AXI_OKAY);
        rd(ADDR_DISABLED, 32'h0, AXI_OKAY);
        wr(8'h1c, 32'h1, AXI_SLVERR);
        wr(ADDR_ACTIVE, 32'hffff, AXI_SLVERR);
        rd(ADDR_ACTIVE, 32'h0, AXI_OKAY);
        $display("test registers done");
        drive_enable_req <= 1'b1;
        warn_source <= w[15:0];
        cyc(2);
        #1 chk(power_stage_enable, 1);
        trip(2);
        trip(5);
        cyc(3);
        #1 chk({tripped_flag, power_stage_enable, trip_message}, 5);
        rd(ADDR_ACTIVE, 32'h24, AXI_OKAY);
        rd(ADDR_FIRST, 32'h23, AXI_OKAY);
        rd(ADDR_HIST0, 32'h6, AXI_OKAY);
        rd(ADDR_HIST0 + 8'h4, 32'h3, AXI_OKAY);
        rd(ADDR_WARN, {16'h0, w[15:0]}, AXI_OKAY);
        @(posedge aclk);
        #1 f = healthy_status_indicator;
        cyc(FLASH);
        #1 chk(healthy_status_indicator, !f);
        @(posedge aclk);
        key_attempt_blocked <= 1'b1;
        @(posedge aclk);
        key_attempt_blocked <= 1'b0;
        #1 chk({key_blocked_alert, tripped_flag}, 3);
        @(posedge aclk);
        ack_key <= 1'b1;
        @(posedge aclk);
        ack_key <= 1'b0;
        cyc(2);
        #1 chk({trip_message, tripped_flag}, 1);
        wr(ADDR_CMD, 32'h4, AXI_OKAY);
        rd(ADDR_STATUS, 32'h13, AXI_OKAY);
        wr(ADDR_CMD, 32'h2, AXI_OKAY);
        rd(ADDR_STATUS, 32'h3, AXI_OKAY);
        $display("test trip latch done");
        wr(ADDR_CTRL, 32'h4, AXI_OKAY);
        for (m = 0; m < 4; m++) begin
            @(posedge aclk);
            trip_source[m + 8] <= 1'b1;
            clr(m);
            rd(ADDR_ACTIVE, 32'h1 << (m + 8), AXI_OKAY);
            @(posedge aclk);
            trip_source[m + 8] <= 1'b0;
            clr(m);
            #1 chk({tripped_flag, healthy_status_indicator_output, healthy_status_indicator}, 3);
            rd(ADDR_FIRST, m ? m + 9 : 3, AXI_OKAY);
        end
        $display("test reset requests done");
        wr(ADDR_CTRL, 32'h2, AXI_OKAY);
        #1 chk(healthy_status_indicator_output, 0);
        trip(1);
        #1 chk(healthy_status_indicator_output, 1);
        clr(0);
        wr(ADDR_DISABLED, 32'h80, AXI_OKAY);
        rd(ADDR_DISABLED, 32'h80, AXI_OKAY);
        @(posedge aclk);
        trip_source[7] <= 1'b1;
        cyc(3);
        #1 chk({tripped_flag, power_stage_enable}, 1);
        @(posedge aclk);
        trip_source[7] <= 1'b0;
        wr(ADDR_DISABLED, 32'h0, AXI_OKAY);
        $display("test polarity and mask done");
        wr(ADDR_CTRL, 32'h1, AXI_OKAY);
        trip(0);
        cyc(AUTO / 2);
        #1 chk({auto_recovery_enable, tripped_flag}, 3);
        cyc(AUTO);
        #1 chk(tripped_flag, 0);
        wr(ADDR_CTRL, 32'h0, AXI_OKAY);
        $display("test auto recovery done");
        trip(3);
        @(posedge aclk);
        aresetn <= 1'b0;
        cyc(2);
        aresetn <= 1'b1;
        cyc(1);
        #1 chk(tripped_flag, 0);
        rd(ADDR_ACTIVE, 32'h0, AXI_OKAY);
        $display("test power cycle done");
        stop_test();
    end
endmodule
